// >>> core/sifd_pkg.sv
`default_nettype none
package sifd_pkg;
  // apb map
  localparam logic [11:0] SIFD_OFF_ASSIGN0   = 12'h000;
  localparam logic [11:0] SIFD_OFF_ASSIGN1   = 12'h004;
  localparam logic [11:0] SIFD_OFF_CONFIG    = 12'h008;
  localparam logic [11:0] SIFD_OFF_VIBSET    = 12'h00C;
  localparam logic [11:0] SIFD_OFF_GEAR_NUM  = 12'h010;
  localparam logic [11:0] SIFD_OFF_GEAR_DEN  = 12'h014;
  localparam logic [11:0] SIFD_OFF_ENC_RES   = 12'h018;
  localparam logic [11:0] SIFD_OFF_PULSE_HZ  = 12'h01C;
  localparam logic [11:0] SIFD_OFF_STATUS    = 12'h020;
  localparam logic [11:0] SIFD_OFF_SPEED     = 12'h024;
  localparam logic [11:0] SIFD_OFF_STEPSPD   = 12'h028;
  localparam logic [11:0] SIFD_OFF_VIBSTAT   = 12'h02C;
  // function codes
  localparam logic [6:0] SIFD_FN_VIB_SEL0   = 7'h39;
  localparam logic [6:0] SIFD_FN_VIB_SEL1   = 7'h3A;
  localparam logic [6:0] SIFD_FN_ADDR0      = 7'h3C;
  localparam logic [6:0] SIFD_FN_EXT_ALARM  = 7'h45;
  localparam logic [6:0] SIFD_FN_PULSE_SPD  = 7'h46;
  localparam logic [6:0] SIFD_FN_TABLE_SEL  = 7'h4D;
  localparam logic [6:0] SIFD_FN_STEP0      = 7'h33;
  // disable frequency, 0.1 Hz units
  localparam logic [15:0] SIFD_FREQ_DISABLE = 16'h0BB8;
  localparam int          SIFD_RPM_PER_HZ   = 60;
  // reset values
  localparam logic [31:0] SIFD_RST_ASSIGN   = 32'h0000_0000;
  localparam logic [15:0] SIFD_RST_FREQ     = 16'h0BB8;
  localparam logic [15:0] SIFD_RST_RATIO    = 16'h0000;
  localparam logic [31:0] SIFD_RST_GEAR     = 32'h0000_0001;
  localparam logic [31:0] SIFD_RST_ENC      = 32'h0002_0000;
  // position modes
  typedef enum logic [4:0] {
    SIFD_MODE_IMMEDIATE = 5'b00001,
    SIFD_MODE_TABLE     = 5'b00010,
    SIFD_MODE_ADDR_ERR  = 5'b00100,
    SIFD_MODE_SEQ_START = 5'b01000,
    SIFD_MODE_HOMING    = 5'b10000
  } sifd_mode_t;
endpackage
`default_nettype wire

// >>> core/sifd_decoder.sv
// Behaviour
// - vibration selects form 2-bit index, select 1 upper, picks frequency/ratio pair
// - unassigned functions read OFF; pair 0 stays in effect
// - selected frequency of 300.0 Hz disables vibration suppression
// - four address inputs form binary address 0..15, first input lsb
// - address 0 with table enabled acts per sequential-start setting 0..3
// - external alarm function ON raises the terminal alarm
// - steps all OFF: pulse speed function ON uses pulse frequency, else analog
// - pulse rpm = freq * 60 * gear numerator / denominator / resolution
// - table-select ON uses internal table, OFF or unassigned uses immediate data
// - table-select change is accepted at any moment
// - steps all OFF take pulse or analog speed, other combinations pick stored speed
`default_nettype none
module sifd_decoder
  import sifd_pkg::*;
#(
  parameter int N_TERM = 8
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // terminals
  input  wire logic [7:0]  digital_input_terminal,
  // decoded
  output logic             external_terminal_alarm,
  output logic [1:0]       vib_index,
  output logic             vib_enable,
  output logic [15:0]      vib_freq,
  output logic [15:0]      vib_ratio,
  output logic [3:0]       pos_addr,
  output logic [4:0]       pos_mode,
  output logic             speed_from_pulse,
  output logic             speed_from_analog,
  output logic [2:0]       speed_step,
  output logic [31:0]      speed_rpm
);
  import sifd_pkg::*;

  typedef struct packed {
    logic [7:0]      sync1;
    logic [7:0]      sync2;
    logic [63:0]     assign_map;
    logic [1:0]      seq_set;
    logic            table_en;
    logic [127:0]    vib_set;
    logic [31:0]     gear_num;
    logic [31:0]     gear_den;
    logic [31:0]     enc_res;
    logic [31:0]     pulse_hz;
    logic            alarm;
    logic [1:0]      vidx;
    logic [3:0]      addr;
    sifd_mode_t      mode;
    logic            pulse_sel;
    logic            analog_sel;
    logic [2:0]      step;
    logic [31:0]     rpm;
    logic [31:0]     rdata;
  } sifd_state_t;

  sifd_state_t state_reg;
  sifd_state_t state_next;

  ////////////////////////////////////////////////////////////////////////
  // function lookup: OR of every terminal assigned this code
  function automatic logic fn_on(input logic [63:0] amap, input logic [7:0] term,
                                 input logic [6:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_TERM; i++) begin
      if (amap[i*8 +: 7] == code && code != 7'h00) begin
        hit = hit | term[i];
      end
    end
    return hit;
  endfunction

  logic        f_vs0;
  logic        f_vs1;
  logic [3:0]  f_addr;
  logic        f_alarm;
  logic        f_pulse;
  logic        f_table;
  logic [2:0]  f_step;
  logic [63:0] pulse_prod;
  logic [63:0] pulse_div;
  logic        wr_en;
  logic        rd_en;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  always_comb begin
    // unassigned codes never match, so read OFF
    f_vs0   = fn_on(state_reg.assign_map, state_reg.sync2, SIFD_FN_VIB_SEL0);
    f_vs1   = fn_on(state_reg.assign_map, state_reg.sync2, SIFD_FN_VIB_SEL1);
    for (int b = 0; b < 4; b++) begin
      f_addr[b] = fn_on(state_reg.assign_map, state_reg.sync2, SIFD_FN_ADDR0 + 7'(b));
    end
    for (int s = 0; s < 3; s++) begin
      f_step[s] = fn_on(state_reg.assign_map, state_reg.sync2, SIFD_FN_STEP0 + 7'(s));
    end
    f_alarm = fn_on(state_reg.assign_map, state_reg.sync2, SIFD_FN_EXT_ALARM);
    f_pulse = fn_on(state_reg.assign_map, state_reg.sync2, SIFD_FN_PULSE_SPD);
    f_table = fn_on(state_reg.assign_map, state_reg.sync2, SIFD_FN_TABLE_SEL);
    pulse_prod = 64'(state_reg.pulse_hz) * 64'(SIFD_RPM_PER_HZ) * 64'(state_reg.gear_num);
    pulse_div  = 64'(state_reg.gear_den) * 64'(state_reg.enc_res);
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = digital_input_terminal;
    state_next.sync2 = state_reg.sync1;
    state_next.vidx  = {f_vs1, f_vs0};
    state_next.alarm = f_alarm;
    state_next.addr  = f_addr;
    state_next.step  = f_step;
    // no stop needed, follows input each cycle
    if (!f_table || !state_reg.table_en) begin
      state_next.mode = SIFD_MODE_IMMEDIATE;
    end else if (f_addr != 4'h0) begin
      state_next.mode = SIFD_MODE_TABLE;
    end else begin
      case (state_reg.seq_set)
        2'h0:    state_next.mode = SIFD_MODE_ADDR_ERR;
        2'h1:    state_next.mode = SIFD_MODE_SEQ_START;
        2'h2:    state_next.mode = SIFD_MODE_HOMING;
        2'h3:    state_next.mode = SIFD_MODE_IMMEDIATE;
        default: state_next.mode = SIFD_MODE_ADDR_ERR;
      endcase
    end
    state_next.pulse_sel  = (f_step == 3'h0) & f_pulse;
    state_next.analog_sel = (f_step == 3'h0) & ~f_pulse;
    if (pulse_div != 64'h0) begin
      state_next.rpm = 32'(pulse_prod / pulse_div);
    end else begin
      state_next.rpm = 32'h0000_0000;
    end
    // apb write
    if (wr_en) begin
      case (paddr)
        SIFD_OFF_ASSIGN0:  state_next.assign_map[31:0]  = pwdata;
        SIFD_OFF_ASSIGN1:  state_next.assign_map[63:32] = pwdata;
        SIFD_OFF_CONFIG: begin
          state_next.seq_set  = pwdata[1:0];
          state_next.table_en = pwdata[4];
        end
        SIFD_OFF_VIBSET:   state_next.vib_set[pwdata[31:30]*32 +: 32] = {2'h0, pwdata[29:0]};
        SIFD_OFF_GEAR_NUM: state_next.gear_num = pwdata;
        SIFD_OFF_GEAR_DEN: state_next.gear_den = pwdata;
        SIFD_OFF_ENC_RES:  state_next.enc_res  = pwdata;
        SIFD_OFF_PULSE_HZ: state_next.pulse_hz = pwdata;
        default: ;
      endcase
    end
    // apb read data captured in setup cycle
    if (rd_en) begin
      case (paddr)
        SIFD_OFF_ASSIGN0:  state_next.rdata = state_reg.assign_map[31:0];
        SIFD_OFF_ASSIGN1:  state_next.rdata = state_reg.assign_map[63:32];
        SIFD_OFF_CONFIG:   state_next.rdata = {27'h0, state_reg.table_en, 2'h0,
                                               state_reg.seq_set};
        SIFD_OFF_GEAR_NUM: state_next.rdata = state_reg.gear_num;
        SIFD_OFF_GEAR_DEN: state_next.rdata = state_reg.gear_den;
        SIFD_OFF_ENC_RES:  state_next.rdata = state_reg.enc_res;
        SIFD_OFF_PULSE_HZ: state_next.rdata = state_reg.pulse_hz;
        SIFD_OFF_STATUS:   state_next.rdata = {state_reg.mode, state_reg.step, state_reg.addr,
                                               state_reg.vidx, state_reg.pulse_sel,
                                               state_reg.analog_sel, state_reg.alarm,
                                               vib_enable, 6'h00, state_reg.sync2};
        SIFD_OFF_SPEED:    state_next.rdata = state_reg.rpm;
        SIFD_OFF_STEPSPD:  state_next.rdata = {29'h0, state_reg.step};
        SIFD_OFF_VIBSTAT:  state_next.rdata = {vib_ratio, vib_freq};
        default:           state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg            <= '0;
      state_reg.mode       <= SIFD_MODE_IMMEDIATE;
      state_reg.analog_sel <= 1'b1;
      state_reg.assign_map <= {SIFD_RST_ASSIGN, SIFD_RST_ASSIGN};
      state_reg.vib_set    <= {4{SIFD_RST_RATIO, SIFD_RST_FREQ}};
      state_reg.gear_num   <= SIFD_RST_GEAR;
      state_reg.gear_den   <= SIFD_RST_GEAR;
      state_reg.enc_res    <= SIFD_RST_ENC;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  logic [31:0] vib_word;
  logic        addr_bad;
  assign vib_word   = state_reg.vib_set[state_reg.vidx*32 +: 32];
  assign vib_freq   = vib_word[15:0];
  assign vib_ratio  = vib_word[31:16];
  assign vib_enable = (vib_word[15:0] != SIFD_FREQ_DISABLE);
  assign vib_index  = state_reg.vidx;
  assign external_terminal_alarm = state_reg.alarm;
  assign pos_addr          = state_reg.addr;
  assign pos_mode          = state_reg.mode;
  assign speed_from_pulse  = state_reg.pulse_sel;
  assign speed_from_analog = state_reg.analog_sel;
  assign speed_step        = state_reg.step;
  assign speed_rpm         = state_reg.rpm;
  assign prdata            = state_reg.rdata;
  assign pready            = 1'b1;
  assign addr_bad = (paddr[1:0] != 2'h0) || (paddr > SIFD_OFF_VIBSTAT);
  assign pslverr  = psel & penable & addr_bad;

  ////////////////////////////////////////////////////////////////////////
  chk_vib_index_map: assert property (@(posedge pclk) disable iff (!presetn)
    (vib_index == 2'h1) |->
      vib_freq == state_reg.vib_set[32 +: 16])
    else $error("vibration pair does not follow index");
  chk_vib_disable: assert property (@(posedge pclk) disable iff (!presetn)
    (vib_freq == SIFD_FREQ_DISABLE) |-> !vib_enable)
    else $error("suppression active at disable frequency");
  chk_vib_unassigned: assert property (@(posedge pclk) disable iff (!presetn)
    (!fn_on(state_reg.assign_map, 8'hFF, SIFD_FN_VIB_SEL0) &&
     !fn_on(state_reg.assign_map, 8'hFF, SIFD_FN_VIB_SEL1)) |=> vib_index == 2'h0)
    else $error("unassigned selects moved the pair");
  chk_alarm_follow: assert property (@(posedge pclk) disable iff (!presetn)
    f_alarm |=> external_terminal_alarm)
    else $error("alarm function on but no alarm");
  chk_addr_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pos_addr == $past(f_addr))
    else $error("position address not taken from inputs");
  chk_addr_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (f_table && state_reg.table_en && f_addr == 4'h0 && state_reg.seq_set == 2'h2)
      |=> pos_mode == SIFD_MODE_HOMING)
    else $error("address zero homing missed");
  chk_table_sel: assert property (@(posedge pclk) disable iff (!presetn)
    !f_table |=> pos_mode == SIFD_MODE_IMMEDIATE)
    else $error("table used with selection off");
  chk_table_switch: assert property (@(posedge pclk) disable iff (!presetn)
    (f_table && state_reg.table_en && f_addr != 4'h0) |=> pos_mode == SIFD_MODE_TABLE)
    else $error("table switch not accepted");
  chk_speed_src: assert property (@(posedge pclk) disable iff (!presetn)
    (f_step == 3'h0) |=> (speed_from_pulse ^ speed_from_analog))
    else $error("speed source not chosen");
  chk_step_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (f_step != 3'h0) |=> !speed_from_pulse && !speed_from_analog && speed_step != 3'h0)
    else $error("stored speed not selected");
  chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 state_reg.sync2 == $past(digital_input_terminal, 2))
    else $error("terminal sync depth wrong");

  ////////////////////////////////////////////////////////////////////////
  chk_vib_sel_upper: assert property (@(posedge pclk) disable iff (!presetn)
    (f_vs1 && !f_vs0)
      |=> vib_index == 2'h2)
    else $error("select 1 is not the upper index bit");
  chk_vib_sel_lower: assert property (@(posedge pclk) disable iff (!presetn)
    (!f_vs1 && f_vs0)
      |=> vib_index == 2'h1)
    else $error("select 0 is not the lower index bit");
  chk_vib_ratio_map: assert property (@(posedge pclk) disable iff (!presetn)
    (vib_index == 2'h3)
      |-> vib_ratio == state_reg.vib_set[112 +: 16])
    else $error("inertia ratio does not follow index");
  chk_vib_enable_on: assert property (@(posedge pclk) disable iff (!presetn)
    (vib_freq != SIFD_FREQ_DISABLE)
      |-> vib_enable)
    else $error("suppression off at a working frequency");
  chk_table_unassigned: assert property (@(posedge pclk) disable iff (!presetn)
    !fn_on(state_reg.assign_map, 8'hFF, SIFD_FN_TABLE_SEL)
      |=> pos_mode == SIFD_MODE_IMMEDIATE)
    else $error("unassigned table select read as on");
  chk_alarm_unassigned: assert property (@(posedge pclk) disable iff (!presetn)
    !fn_on(state_reg.assign_map, 8'hFF, SIFD_FN_EXT_ALARM)
      |=> !external_terminal_alarm)
    else $error("unassigned alarm read as on");
  chk_alarm_release: assert property (@(posedge pclk) disable iff (!presetn)
    !f_alarm
      |=> !external_terminal_alarm)
    else $error("alarm held with function off");
  chk_addr_error: assert property (@(posedge pclk) disable iff (!presetn)
    (f_table && state_reg.table_en && f_addr == 4'h0 && state_reg.seq_set == 2'h0)
      |=> pos_mode == SIFD_MODE_ADDR_ERR)
    else $error("address zero error missed");
  chk_seq_start: assert property (@(posedge pclk) disable iff (!presetn)
    (f_table && state_reg.table_en && f_addr == 4'h0 && state_reg.seq_set == 2'h1)
      |=> pos_mode == SIFD_MODE_SEQ_START)
    else $error("address zero sequential start missed");
  chk_addr_immediate: assert property (@(posedge pclk) disable iff (!presetn)
    (f_table && state_reg.table_en && f_addr == 4'h0 && state_reg.seq_set == 2'h3)
      |=> pos_mode == SIFD_MODE_IMMEDIATE)
    else $error("address zero immediate run missed");
  chk_table_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !state_reg.table_en
      |=> pos_mode == SIFD_MODE_IMMEDIATE)
    else $error("table used while disabled");
  chk_mode_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
      |-> $onehot(pos_mode))
    else $error("position mode not one-hot");
  chk_table_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (f_table && state_reg.table_en && f_addr != 4'h0) ##1 !f_table
      |=> pos_mode == SIFD_MODE_IMMEDIATE)
    else $error("table deselect not accepted at once");
  chk_pulse_pick: assert property (@(posedge pclk) disable iff (!presetn)
    (f_step == 3'h0 && f_pulse)
      |=> speed_from_pulse && !speed_from_analog)
    else $error("pulse speed source missed");
  chk_analog_pick: assert property (@(posedge pclk) disable iff (!presetn)
    (f_step == 3'h0 && !f_pulse)
      |=> speed_from_analog && !speed_from_pulse)
    else $error("analog speed source missed");
  chk_rpm_no_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg.pulse_hz == 32'h0000_0000)
      |=> speed_rpm == 32'h0000_0000)
    else $error("speed without pulse frequency");
  chk_step_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1
      speed_step == $past(f_step))
    else $error("step index not taken from selects");
  chk_sync_first: assert property (@(posedge pclk) disable iff (!presetn)
    ##1
      state_reg.sync1 == $past(digital_input_terminal))
    else $error("first sync stage wrong");
  chk_addr_table: assert property (@(posedge pclk) disable iff (!presetn)
    (f_table && state_reg.table_en && f_addr == 4'hF)
      |=> pos_addr == 4'hF && pos_mode == SIFD_MODE_TABLE)
    else $error("address 15 not run from table");
  chk_speed_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
      |-> !(speed_from_pulse && speed_from_analog))
    else $error("two speed sources at once");
endmodule
`default_nettype wire

// >>> tb/sifd_host_model.sv
`default_nettype none
module sifd_host_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // requested levels
  input  wire logic [7:0] want_terms,
  input  wire logic [7:0] vib_mask,
  input  wire logic       motor_stopped,
  // terminals
  output logic      [7:0] digital_input_terminal
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////
  // vibration select terminals follow only while the motor is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_input_terminal <= 8'h00;
    end else begin
      digital_input_terminal <= (want_terms & ~vib_mask) |
        ((motor_stopped ? want_terms : digital_input_terminal) & vib_mask);
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_servo_input_function_decoder.sv
`default_nettype none
module test_servo_input_function_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import sifd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        alarm, vib_en, from_pulse, from_analog, stopped;
  logic [1:0]  vib_idx;
  logic [2:0]  step;
  logic [3:0]  addr;
  logic [4:0]  mode;
  logic [7:0]  terms, want, mask;
  logic [11:0] paddr;
  logic [15:0] vfreq, vratio;
  logic [31:0] pwdata, prdata, rpm, rd;
  logic [15:0] fr [4];
  logic [4:0]  m0 [4];
  int          failures, check_count, cycles;
  ////////////////////////////////////////////////////////////////////
  sifd_decoder #(.N_TERM(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digital_input_terminal(terms),
    .external_terminal_alarm(alarm), .vib_index(vib_idx), .vib_enable(vib_en),
    .vib_freq(vfreq), .vib_ratio(vratio), .pos_addr(addr), .pos_mode(mode),
    .speed_from_pulse(from_pulse), .speed_from_analog(from_analog),
    .speed_step(step), .speed_rpm(rpm));
  sifd_host_model host (
    .pclk(pclk), .presetn(presetn), .want_terms(want), .vib_mask(mask),
    .motor_stopped(stopped), .digital_input_terminal(terms));
  ////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task drive(input logic [7:0] t);
    @(posedge pclk);
    want <= t;
    repeat (5) @(posedge pclk);
    #1;
  endtask
  task results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, want} = '0;
    {mask, stopped, failures, check_count, cycles} = '0;
    mask = 8'h03;
    stopped = 1'b1;
    fr = '{16'h0100, 16'h0200, 16'h0300, SIFD_FREQ_DISABLE};
    m0 = '{SIFD_MODE_ADDR_ERR, SIFD_MODE_SEQ_START, SIFD_MODE_HOMING, SIFD_MODE_IMMEDIATE};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check(vib_en, 1'b0, "reset vib");
    check(mode, SIFD_MODE_IMMEDIATE, "reset mode");
    // nothing assigned yet: every function reads off
    drive(8'hFF);
    check(vib_idx, 2'h0, "idx");
    check(vfreq, SIFD_RST_FREQ, "freq");
    check(alarm, 1'b0, "alarm");
    check(mode, SIFD_MODE_IMMEDIATE, "mode");
    check(from_analog, 1'b1, "analog");
    for (int i = 0; i < 4; i++) apb(1'b1, SIFD_OFF_VIBSET, {i[1:0], 14'(i + 5), fr[i]});
    apb(1'b1, SIFD_OFF_ASSIGN0, 32'h3D3C_3A39);
    apb(1'b1, SIFD_OFF_ASSIGN1, 32'h4645_3F3E);
    apb(1'b1, SIFD_OFF_GEAR_NUM, 32'h0000_0004);
    apb(1'b1, SIFD_OFF_GEAR_DEN, 32'h0000_0005);
    apb(1'b1, SIFD_OFF_ENC_RES, 32'h0000_0008);
    apb(1'b1, SIFD_OFF_PULSE_HZ, 32'h0000_03E8);
    for (int i = 0; i < 4; i++) begin
      drive({6'h00, i[1:0]});
      check(vib_idx, i[1:0], "idx");
      check(vfreq, fr[i], "freq");
      check(vratio, 16'(i + 5), "ratio");
      check(vib_en, fr[i] != SIFD_FREQ_DISABLE, "enable");
      apb(1'b0, SIFD_OFF_VIBSTAT, 32'h0000_0000);
      check(rd, {16'(i + 5), fr[i]}, "vibstat");
    end
    stopped <= 1'b0;
    drive(8'h80);
    check(vib_idx, 2'h3, "held idx");
    check(from_pulse, 1'b1, "pulse");
    check(from_analog, 1'b0, "analog");
    check(rpm, 32'h0000_03E8 * SIFD_RPM_PER_HZ * 32'h4 / 32'h5 / 32'h8, "rpm");
    stopped <= 1'b1;
    // alarm latency: two sync stages then one decode stage
    @(posedge pclk);
    want <= 8'h40;
    repeat (3) @(posedge pclk);
    #1;
    check(alarm, 1'b0, "early");
    @(posedge pclk);
    #1;
    check(alarm, 1'b1, "alarm on");
    check(from_analog, 1'b1, "analog");
    drive(8'h00);
    check(alarm, 1'b0, "alarm off");
    // reassign: address, table select, step 0, alarm, pulse
    mask <= 8'h00;
    apb(1'b1, SIFD_OFF_ASSIGN0, 32'h3F3E_3D3C);
    apb(1'b1, SIFD_OFF_ASSIGN1, 32'h4645_334D);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, SIFD_OFF_CONFIG, {27'h0, 1'b1, 2'h0, s[1:0]});
      drive(8'h10);
      check(mode, m0[s], "addr0 mode");
    end
    for (int a = 1; a < 16; a++) begin
      drive({4'h1, a[3:0]});
      check(addr, a[3:0], "addr");
      check(mode, SIFD_MODE_TABLE, "table");
    end
    drive(8'h0F);
    check(mode, SIFD_MODE_IMMEDIATE, "switch");
    drive(8'hA0);
    check(step, 3'h1, "step");
    check(from_pulse, 1'b0, "pulse");
    check(from_analog, 1'b0, "analog");
    apb(1'b0, SIFD_OFF_SPEED, 32'h0000_0000);
    check(rd, 32'h0000_03E8 * SIFD_RPM_PER_HZ * 32'h4 / 32'h5 / 32'h8, "speed reg");
    check(rerr, 1'b0, "mapped err");
    apb(1'b0, SIFD_OFF_STEPSPD, 32'h0000_0000);
    check(rd, 32'h0000_0001, "step reg");
    apb(1'b0, SIFD_OFF_STATUS, 32'h0000_0000);
    check(rd, 32'h0900_40A0, "status");
    apb(1'b0, 12'h030, 32'h0000_0000);
    check(rd, 32'h0000_0000, "unmapped data");
    check(rerr, 1'b1, "unmapped err");
    results();
  end
endmodule
`default_nettype wire
